// File: rtl/adcl_irq.sv
// sticky interrupt status with write-one-to-clear and mask
`timescale 1ns/1ps
module adcl_irq (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic [2:0] i_event,
    input wire logic [2:0] i_clear,
    input wire logic [2:0] i_mask,
    output logic [2:0] o_status,
    output logic o_irq
);
    import adcl_pkg::*;

    typedef struct packed {
        logic [2:0] status;
        logic irq;
    } adcl_irq_state_t;

    adcl_irq_state_t st;
    adcl_irq_state_t next_st;

    // a set arriving with its clear wins, so no event is lost
    always_comb
    begin
        next_st = st;
        next_st.status = (st.status & ~i_clear) | i_event;
        next_st.irq = |(next_st.status & i_mask);
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign o_status = st.status;
    assign o_irq = st.irq;
endmodule

// File: rtl/adcl_pkg.sv
// shared constants and carrier types for the alarm driven dac clear block
package adcl_pkg;
    // register indices; the byte address is four times the index
    localparam logic [9:0] IDX_CLR_SOURCE = 10'h053;
    localparam logic [9:0] IDX_AUTO_EN = 10'h054;
    localparam logic [9:0] IDX_SW_CLR = 10'h055;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h060;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h061;
    localparam logic [9:0] IDX_CLR_STATE = 10'h062;
    localparam logic [9:0] IDX_ALARM_VIEW = 10'h063;

    // reset values and writable bits of the 16-bit registers
    localparam logic [15:0] RST_CLR_SOURCE = 16'h0004;
    localparam logic [15:0] RST_AUTO_EN = 16'h0000;
    localparam logic [15:0] RST_SW_CLR = 16'h0000;
    localparam logic [15:0] MSK_CLR_SOURCE = 16'h7FFC;
    localparam logic [15:0] MSK_DAC_FIELD = 16'h7FF8;
    localparam logic [2:0] RST_IRQ_MASK = 3'h0;

    // field positions
    localparam int DAC_FIELD_LSB = 3;
    localparam int SRC_FIELD_LSB = 2;
    localparam int THERMAL_SEL_BIT = 2;
    localparam int NUM_DAC = 12;
    localparam int NUM_SRC = 13;
    localparam int NUM_EVT = 3;

    // interrupt event bit positions
    localparam int EVT_ALARM_ON = 0;
    localparam int EVT_THERMAL_ON = 1;
    localparam int EVT_ALARM_OFF = 2;

    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // alarm status bits, ordered as the source-select field (bit 14 first)
    typedef struct packed {
        logic input0_alarm_status;
        logic input1_alarm_status;
        logic input2_alarm_status;
        logic input3_alarm_status;
        logic local_temp_low_status;
        logic local_temp_high_status;
        logic remote1_low_status;
        logic remote1_high_status;
        logic remote2_low_status;
        logic remote2_high_status;
        logic remote1_fail_status;
        logic remote2_fail_status;
        logic over_temperature_status;
    } adcl_alarm_t;

    // axi4-lite master to slave
    typedef struct packed {
        logic awvalid;
        logic [11:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [11:0] araddr;
        logic rready;
    } adcl_axi_in_t;

    // axi4-lite slave to master
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } adcl_axi_out_t;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } adcl_wr_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } adcl_rd_t;
endpackage

// File: rtl/adcl_qualify.sv
// per-dac alarm qualification against source select and auto-clear enables
`timescale 1ns/1ps
module adcl_qualify (
    input wire logic [15:0] i_source,
    input wire logic [15:0] i_enable,
    input wire adcl_pkg::adcl_alarm_t i_alarm,
    output logic [11:0] o_alarm_clear,
    output logic o_thermal_all
);
    import adcl_pkg::*;

    logic [NUM_SRC-1:0] alarm_vec;
    logic any_qualified;

    // a source with select 0 still shows its status but clears nothing
    assign alarm_vec = i_alarm;
    assign any_qualified = |(alarm_vec[NUM_SRC-1:1]
        & i_source[SRC_FIELD_LSB+NUM_SRC-1:SRC_FIELD_LSB+1]);

    // thermal override ignores the per-dac enables entirely
    assign o_thermal_all = i_source[THERMAL_SEL_BIT]
        & i_alarm.over_temperature_status;

    // one gate per dac: bits 14..3 carry dac 11..0
    genvar g;
    generate
        for (g = 0; g < NUM_DAC; g++)
        begin : g_dac
            assign o_alarm_clear[g] = (any_qualified
                & i_enable[DAC_FIELD_LSB+g]) | o_thermal_all;
        end
    endgenerate
endmodule

// File: rtl/adcl_top.sv
// alarm driven dac clear control with axi4-lite register slave
`timescale 1ns/1ps
module adcl_top (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire adcl_pkg::adcl_alarm_t i_alarm,
    input wire adcl_pkg::adcl_axi_in_t i_axi,
    output adcl_pkg::adcl_axi_out_t o_axi,
    output logic [11:0] o_dac_clear,
    output logic o_irq
);
    import adcl_pkg::*;

    typedef struct packed {
        adcl_wr_t wr_state;
        adcl_rd_t rd_state;
        logic aw_got;
        logic w_got;
        logic [11:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        adcl_axi_out_t axi;
        logic [15:0] clr_source;
        logic [15:0] auto_en;
        logic [15:0] sw_clr;
        logic [2:0] irq_mask;
        logic [11:0] alarm_state;
        logic thermal_state;
        logic [11:0] dac_clear;
    } adcl_top_state_t;

    localparam adcl_top_state_t ST_RESET = '{
        wr_state: WR_IDLE,
        rd_state: RD_IDLE,
        aw_got: 1'b0,
        w_got: 1'b0,
        awaddr: 12'h000,
        wdata: 32'h00000000,
        wstrb: 4'h0,
        axi: '{
            awready: 1'b1,
            wready: 1'b1,
            bvalid: 1'b0,
            bresp: RESP_OKAY,
            arready: 1'b1,
            rvalid: 1'b0,
            rdata: 32'h00000000,
            rresp: RESP_OKAY
        },
        clr_source: RST_CLR_SOURCE,
        auto_en: RST_AUTO_EN,
        sw_clr: RST_SW_CLR,
        irq_mask: RST_IRQ_MASK,
        alarm_state: 12'h000,
        thermal_state: 1'b0,
        dac_clear: 12'h000
    };

    adcl_top_state_t st;
    adcl_top_state_t next_st;

    logic [11:0] alarm_clear;
    logic thermal_all;
    logic [2:0] irq_event;
    logic [2:0] irq_clear;
    logic [2:0] irq_status;
    logic irq_level;
    logic wr_land;

    // merge a write into a 16-bit register through its byte strobes
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] data,
        input logic [3:0] strb,
        input logic [15:0] wmask
    );
        logic [15:0] r;
        r = old;
        if (strb[0])
        begin
            r[7:0] = data[7:0];
        end
        if (strb[1])
        begin
            r[15:8] = data[15:8];
        end
        return r & wmask;
    endfunction

    // true when the word index names a mapped register
    function automatic logic mapped(input logic [9:0] idx);
        logic hit;
        hit = 1'b0;
        case (idx)
            IDX_CLR_SOURCE, IDX_AUTO_EN, IDX_SW_CLR,
            IDX_IRQ_STATUS, IDX_IRQ_MASK,
            IDX_CLR_STATE, IDX_ALARM_VIEW:
            begin
                hit = 1'b1;
            end
            default:
            begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction

    // alarm qualification uses the registered source and enable fields
    adcl_qualify u_qualify (
        .i_source(st.clr_source),
        .i_enable(st.auto_en),
        .i_alarm(i_alarm),
        .o_alarm_clear(alarm_clear),
        .o_thermal_all(thermal_all)
    );

    // sticky events: clear onset, thermal onset, clear release
    adcl_irq u_irq (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_event(irq_event),
        .i_clear(irq_clear),
        .i_mask(st.irq_mask),
        .o_status(irq_status),
        .o_irq(irq_level)
    );

    // edges of the alarm driven clear feed the interrupt events
    always_comb
    begin
        irq_event = '0;
        irq_event[EVT_ALARM_ON] = (|alarm_clear) & ~(|st.alarm_state);
        irq_event[EVT_THERMAL_ON] = thermal_all & ~st.thermal_state;
        irq_event[EVT_ALARM_OFF] = ~(|alarm_clear) & (|st.alarm_state);
    end

    // a write lands in the one cycle both halves are held and no answer
    // is pending; everything that reacts to a write keys off this strobe
    assign wr_land = (st.wr_state == WR_IDLE) && st.aw_got && st.w_got;

    // write-one-to-clear strobe, only in the cycle the write is applied
    always_comb
    begin
        irq_clear = '0;
        if (wr_land
            && st.awaddr[11:2] == IDX_IRQ_STATUS && st.wstrb[0])
        begin
            irq_clear = st.wdata[NUM_EVT-1:0];
        end
    end

    // next state: bus slave, registers and dac clear outputs
    // the slave keeps one write and one read in flight; a new address is
    // refused until the master has taken the previous answer, which costs
    // a cycle per access but needs no queue behind the registers
    always_comb
    begin
        next_st = st;

        // address and data channels are taken independently
        if (st.axi.awready && i_axi.awvalid)
        begin
            next_st.axi.awready = 1'b0;
            next_st.aw_got = 1'b1;
            next_st.awaddr = i_axi.awaddr;
        end
        if (st.axi.wready && i_axi.wvalid)
        begin
            next_st.axi.wready = 1'b0;
            next_st.w_got = 1'b1;
            next_st.wdata = i_axi.wdata;
            next_st.wstrb = i_axi.wstrb;
        end

        // write sequencing: apply once both halves are held
        case (st.wr_state)
            WR_IDLE:
            begin
                if (wr_land)
                begin
                    next_st.axi.bvalid = 1'b1;
                    next_st.axi.bresp = mapped(st.awaddr[11:2])
                        ? RESP_OKAY : RESP_SLVERR;
                    next_st.wr_state = WR_RESP;
                    case (st.awaddr[11:2])
                        IDX_CLR_SOURCE:
                        begin
                            next_st.clr_source = merge16(st.clr_source,
                                st.wdata, st.wstrb, MSK_CLR_SOURCE);
                        end
                        IDX_AUTO_EN:
                        begin
                            next_st.auto_en = merge16(st.auto_en,
                                st.wdata, st.wstrb, MSK_DAC_FIELD);
                        end
                        IDX_SW_CLR:
                        begin
                            next_st.sw_clr = merge16(st.sw_clr,
                                st.wdata, st.wstrb, MSK_DAC_FIELD);
                        end
                        IDX_IRQ_STATUS:
                        begin
                            // write-one-to-clear, via the irq_clear strobe
                        end
                        IDX_IRQ_MASK:
                        begin
                            if (st.wstrb[0])
                            begin
                                next_st.irq_mask = st.wdata[NUM_EVT-1:0];
                            end
                        end
                        IDX_CLR_STATE, IDX_ALARM_VIEW:
                        begin
                            // read-only views take the write and ignore it
                        end
                        default:
                        begin
                            // unmapped: answered with an error, no effect
                            next_st.irq_mask = st.irq_mask;
                        end
                    endcase
                end
            end
            WR_RESP:
            begin
                // response stands until the master takes it
                if (i_axi.bready)
                begin
                    next_st.axi.bvalid = 1'b0;
                    next_st.aw_got = 1'b0;
                    next_st.w_got = 1'b0;
                    next_st.axi.awready = 1'b1;
                    next_st.axi.wready = 1'b1;
                    next_st.wr_state = WR_IDLE;
                end
            end
            default:
            begin
                next_st.wr_state = WR_IDLE;
            end
        endcase

        // read sequencing: data is captured at the address handshake
        case (st.rd_state)
            RD_IDLE:
            begin
                if (i_axi.arvalid)
                begin
                    next_st.axi.arready = 1'b0;
                    next_st.axi.rvalid = 1'b1;
                    next_st.axi.rresp = mapped(i_axi.araddr[11:2])
                        ? RESP_OKAY : RESP_SLVERR;
                    next_st.axi.rdata = 32'h00000000;
                    case (i_axi.araddr[11:2])
                        IDX_CLR_SOURCE:
                        begin
                            next_st.axi.rdata[15:0] = st.clr_source;
                        end
                        IDX_AUTO_EN:
                        begin
                            next_st.axi.rdata[15:0] = st.auto_en;
                        end
                        IDX_SW_CLR:
                        begin
                            next_st.axi.rdata[15:0] = st.sw_clr;
                        end
                        IDX_IRQ_STATUS:
                        begin
                            next_st.axi.rdata[NUM_EVT-1:0] = irq_status;
                        end
                        IDX_IRQ_MASK:
                        begin
                            next_st.axi.rdata[NUM_EVT-1:0] = st.irq_mask;
                        end
                        IDX_CLR_STATE:
                        begin
                            next_st.axi.rdata[DAC_FIELD_LSB+NUM_DAC-1:
                                DAC_FIELD_LSB] = st.dac_clear;
                        end
                        IDX_ALARM_VIEW:
                        begin
                            next_st.axi.rdata[SRC_FIELD_LSB+NUM_SRC-1:
                                SRC_FIELD_LSB] = i_alarm;
                        end
                        default:
                        begin
                            next_st.axi.rdata = 32'h00000000;
                        end
                    endcase
                    next_st.rd_state = RD_DATA;
                end
            end
            RD_DATA:
            begin
                if (i_axi.rready)
                begin
                    next_st.axi.rvalid = 1'b0;
                    next_st.axi.arready = 1'b1;
                    next_st.rd_state = RD_IDLE;
                end
            end
            default:
            begin
                next_st.rd_state = RD_IDLE;
            end
        endcase

        // no update-mode input: the clear overrides either mode alike
        next_st.alarm_state = alarm_clear;
        next_st.thermal_state = thermal_all;
        // held for as long as any contributing status stays set
        next_st.dac_clear = alarm_clear
            | st.sw_clr[DAC_FIELD_LSB+NUM_DAC-1:DAC_FIELD_LSB];
    end

    // single register stage for all state
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            st <= ST_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    // every output is a flop of the state or of the interrupt block
    assign o_axi = st.axi;
    assign o_dac_clear = st.dac_clear;
    assign o_irq = irq_level;
endmodule

// File: test/adcl_checker.sv
// port-level assertion checker for the alarm driven dac clear block
`timescale 1ns/1ps
module adcl_checker (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire adcl_pkg::adcl_alarm_t i_alarm,
    input wire adcl_pkg::adcl_axi_in_t i_axi,
    input wire adcl_pkg::adcl_axi_out_t o_axi,
    input wire logic [11:0] o_dac_clear,
    input wire logic o_irq
);
    import adcl_pkg::*;
    logic [15:0] src_q, en_q, sw_q, d_q, bm_q;
    logic [11:0] sw_dac, exp_clr;
    logic [9:0] ix_q;
    logic go;

    // both halves taken and no answer yet: the design writes at this edge
    assign go = !o_axi.awready && !o_axi.wready && !o_axi.bvalid;
    assign sw_dac = sw_q[14:3];
    assign exp_clr = ({12{|(src_q[14:3] & i_alarm[12:1])}} & en_q[14:3])
        | {12{src_q[2] & i_alarm[0]}} | sw_dac;

    function automatic logic [15:0] upd(input logic [15:0] o, m);
        upd = (o & ~(bm_q & m)) | (d_q & bm_q & m);
    endfunction

    // shadow copy of the control registers, rebuilt from bus traffic
    always_ff @(posedge i_core_clk)
    begin
        if (i_axi.awvalid && o_axi.awready)
            ix_q <= i_axi.awaddr[11:2];
        if (i_axi.wvalid && o_axi.wready)
        begin
            d_q <= i_axi.wdata[15:0];
            bm_q <= {{8{i_axi.wstrb[1]}}, {8{i_axi.wstrb[0]}}};
        end
        if (!i_rst_b)
        begin
            src_q <= RST_CLR_SOURCE;
            en_q <= RST_AUTO_EN;
            sw_q <= RST_SW_CLR;
        end
        else if (go)
        begin
            if (ix_q == IDX_CLR_SOURCE)
                src_q <= upd(src_q, MSK_CLR_SOURCE);
            if (ix_q == IDX_AUTO_EN)
                en_q <= upd(en_q, MSK_DAC_FIELD);
            if (ix_q == IDX_SW_CLR)
                sw_q <= upd(sw_q, MSK_DAC_FIELD);
        end
    end

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_b);

    a_clear_match:
        assert property (i_rst_b |=> o_dac_clear == $past(exp_clr))
        else $error("dac clear differs from qualified alarms");
    a_thermal_all:
        assert property (src_q[2] && i_alarm[0] |=> o_dac_clear == 12'hFFF)
        else $error("thermal override missed a dac");
    a_deselect_quiet:
        assert property (sw_q == 16'h0000
            && (src_q[14:2] & i_alarm) == 13'h0000 |=> o_dac_clear == 12'h000)
        else $error("dac cleared with no selected alarm");
    a_sw_forces:
        assert property (i_rst_b |=> &(o_dac_clear | ~$past(sw_dac)))
        else $error("software clear bit not honoured");
    a_source_read:
        assert property (i_axi.arvalid && o_axi.arready
            && i_axi.araddr[11:2] == IDX_CLR_SOURCE
            |=> o_axi.rdata == {16'h0000, $past(src_q)})
        else $error("source register read differs");
    a_read_next:
        assert property (i_axi.arvalid && o_axi.arready |=> o_axi.rvalid)
        else $error("read answer late");
    a_write_next:
        assert property (go |=> o_axi.bvalid)
        else $error("write answer late");
    a_unmapped_err:
        assert property (i_axi.arvalid && o_axi.arready
            && i_axi.araddr[11:2] > IDX_ALARM_VIEW
            |=> o_axi.rresp == RESP_SLVERR && o_axi.rdata == 32'h0)
        else $error("unmapped read not refused");
    a_unmapped_wr:
        assert property (go && ix_q > IDX_ALARM_VIEW
            |=> o_axi.bresp == RESP_SLVERR)
        else $error("unmapped write not refused");

    c_thermal: cover property (src_q[2] && i_alarm[0]);
    c_soft: cover property (sw_q != 16'h0000);
    c_refused: cover property (o_axi.rvalid && o_axi.rresp == RESP_SLVERR);
    c_wr_refused: cover property (o_axi.bvalid && o_axi.bresp == RESP_SLVERR);
endmodule

bind adcl_top adcl_checker chk_u (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_alarm(i_alarm),
    .i_axi(i_axi),
    .o_axi(o_axi),
    .o_dac_clear(o_dac_clear),
    .o_irq(o_irq)
);

// File: test/alarm_driven_dac_clear_test.sv
// self-checking bench for the alarm driven dac clear block
`timescale 1ns/1ps
module alarm_driven_dac_clear_test;
    import adcl_pkg::*;
    logic i_core_clk;
    logic i_rst_b;
    adcl_alarm_t al;
    adcl_axi_in_t ax;
    adcl_axi_out_t ao;
    logic [11:0] dac;
    logic irq, a;
    logic [31:0] d;
    logic [1:0] r;
    logic [3:0] ws = 4'hF;
    int err_total, compares;
    logic [11:0] adr [6] = '{12'h14C, 12'h150, 12'h154, 12'h180, 12'h184,
        12'h200};
    logic [17:0] rv [6] = '{18'h00004, 18'h0, 18'h0, 18'h0, 18'h0, 18'h20000};

    adcl_top dut_u (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_alarm(al),
        .i_axi(ax),
        .o_axi(ao),
        .o_dac_clear(dac),
        .o_irq(irq)
    );

    initial
    begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            err_total++;
            $display("ERROR %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic summarize();
        if (err_total == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [11:0] a_, input logic [15:0] v);
        logic aw, w, b;
        int n;
        @(posedge i_core_clk);
        ax.awaddr <= a_;
        ax.wdata <= {16'h0000, v};
        ax.wstrb <= ws;
        ax.awvalid <= 1'b1;
        ax.wvalid <= 1'b1;
        ax.bready <= 1'b1;
        {aw, w, b} = 3'h7;
        for (n = 0; b && n < 50; n++)
        begin
            @(posedge i_core_clk);
            aw = aw && !ao.awready;
            w = w && !ao.wready;
            b = b && !ao.bvalid;
            r = ao.bresp;
            ax.awvalid <= aw;
            ax.wvalid <= w;
            ax.bready <= b;
        end
        chk({31'h0, b}, 32'h0);
    endtask

    task automatic rd(input logic [11:0] a_, output logic [31:0] dv,
        output logic [1:0] rs);
        logic ar, rr;
        int n;
        @(posedge i_core_clk);
        ax.araddr <= a_;
        ax.arvalid <= 1'b1;
        ax.rready <= 1'b1;
        {ar, rr} = 2'h3;
        for (n = 0; rr && n < 50; n++)
        begin
            @(posedge i_core_clk);
            ar = ar && !ao.arready;
            rr = rr && !ao.rvalid;
            dv = ao.rdata;
            rs = ao.rresp;
            ax.arvalid <= ar;
            ax.rready <= rr;
        end
        chk({31'h0, rr}, 32'h0);
    endtask

    task automatic setal(input logic [12:0] v);
        @(posedge i_core_clk);
        al <= v;
    endtask

    // output is registered; let the alarm and register stages land first
    task automatic dchk(input logic [11:0] e);
        repeat (3) @(posedge i_core_clk);
        chk({20'h0, dac}, {20'h0, e});
        rd(12'h188, d, r);
        chk(d, {17'h0, e, 3'h0});
    endtask

    initial
    begin
        err_total = 0;
        compares = 0;
        i_rst_b = 1'b0;
        ax = '0;
        al = '0;
        repeat (12) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        // reset values, then a place with no register behind it
        for (int k = 0; k < 6; k++)
        begin
            rd(adr[k], d, r);
            chk({14'h0, r, d[15:0]}, {14'h0, rv[k]});
        end
        // a write to no register is refused; strobes pick single bytes
        wr(12'h200, 16'hFFFF);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        ws = 4'h1;
        wr(12'h150, 16'hFFFF);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
        ws = 4'h2;
        wr(12'h150, 16'h0000);
        rd(12'h150, d, r);
        chk(d, 32'h00F8);
        ws = 4'hF;
        wr(12'h14C, 16'hFFFF);
        rd(12'h14C, d, r);
        chk(d, 32'h7FFC);
        // each source but over temperature alone, then all the others, over a sparse enable
        wr(12'h150, 16'h5550);
        for (int k = 0; k < 12; k++)
        begin
            wr(12'h14C, 16'h0008 << k);
            setal(13'h0002 << k);
            dchk(12'hAAA);
            setal(13'h1FFE & ~(13'h0002 << k));
            dchk(12'h000);
        end
        // over temperature ignores the enables, in both directions
        wr(12'h180, 16'h0007);
        wr(12'h14C, 16'h0004);
        wr(12'h150, 16'h0000);
        setal(13'h0001);
        dchk(12'hFFF);
        wr(12'h14C, 16'h0000);
        wr(12'h150, 16'h7FF8);
        dchk(12'h000);
        setal(13'h0000);
        // began, override and ended events, mask flips the line
        rd(12'h180, d, r);
        chk(d, 32'h7);
        a = irq;
        wr(12'h184, 16'h0007);
        rd(12'h184, d, r);
        chk({d[30:0], a ^ irq}, 32'hF);
        wr(12'h180, 16'h0007);
        rd(12'h180, d, r);
        chk({d[30:0], irq}, 32'h0);
        wr(12'h184, 16'h0000);
        repeat (3) @(posedge i_core_clk);
        chk({31'h0, irq}, 32'h0);
        // software clear with no alarm present
        wr(12'h154, 16'h7FF8);
        dchk(12'hFFF);
        wr(12'h154, 16'h0008);
        dchk(12'h001);
        wr(12'h154, 16'h0000);
        // two selected alarms, one drops, the clear must stay
        wr(12'h14C, 16'h7FF8);
        setal(13'h1002);
        dchk(12'hFFF);
        rd(12'h18C, d, r);
        chk(d, 32'h4008);
        setal(13'h0002);
        dchk(12'hFFF);
        setal(13'h0000);
        dchk(12'h000);
        summarize();
    end

    // hang guard, far beyond the few hundred cycles the run needs
    initial
    begin
        #100000;
        err_total++;
        $display("ERROR %0t: run did not finish", $time);
        summarize();
    end
endmodule
